// [rtl/raw_sock_defs.svh]
// Constants for the raw socket engine: register offsets, field positions, codes, sizes.
// Assumes byte addressing on the register bus, one 32-bit word per register.
`ifndef RAW_SOCK_DEFS_SVH
`define RAW_SOCK_DEFS_SVH

`define OFS_MODE 8'h00
`define OFS_COMMAND 8'h04
`define OFS_STATE 8'h08
`define OFS_IRQ 8'h0c
`define OFS_PROTO 8'h10
`define OFS_TX_WRSIZE 8'h14
`define OFS_TX_FREE 8'h18
`define OFS_RX_STORED 8'h1c
`define OFS_RX_FIFO 8'h20
`define OFS_TX_FIFO 8'h24
`define OFS_MAC_HI 8'h28
`define OFS_MAC_LO 8'h2c
`define OFS_DEST_IP 8'h30

`define MODE_RAW_IP 4'h3
`define MODE_RAW_ETH 4'h4
`define MODE_FILTER_BIT 6
`define PROTO_TCP 8'h06
`define PROTO_UDP 8'h11

`define CODE_CLOSED 8'h00
`define CODE_RAW_IP 8'h0a
`define CODE_RAW_ETH 8'h0b

`define CMD_OPEN 8'h01
`define CMD_CLOSE 8'h10
`define CMD_SEND 8'h20
`define CMD_RECEIVE_DONE_COMMAND 8'h40
`define IRQ_SEND_BIT 0

`define BUF_AW 11
`define BUF_BYTES 12'h800
`define RX_RESERVE 12'h008
`define HDR_IP 12'h006
`define HDR_ETH 12'h002
`define ETH_MIN_LEN 12'h03c
`define ETHERTYPE_IP 16'h0800
`define IP_VER_IHL 8'h45
`define IP_HDR_LEN 12'h014
`define IP_PAYLOAD_OFS 12'h022
`define TAIL_LAST 4'ha

`endif

// [rtl/raw_sock_pkg.sv]
// Types of the raw socket engine: state enums and the state records of each module.
// Assumes raw_sock_defs.svh is on the include path.
`include "raw_sock_defs.svh"
`default_nettype none

package raw_sock_pkg;

	typedef enum logic [1:0] {SK_CLOSED, SK_IP, SK_ETH} sock_t;
	typedef enum logic {RX_FRAME, RX_TAIL} rx_t;
	typedef enum logic {TX_IDLE, TX_RUN} tx_t;

	typedef struct packed {
		logic mac_ok;
		logic frag;
		logic [15:0] etype;
		logic [7:0] vihl;
		logic [15:0] tot;
		logic [7:0] proto;
		logic [31:0] src;
	} cls_t;

	typedef struct packed {
		tx_t st;
		logic [11:0] i;
		logic [11:0] n;
		logic [11:0] len;
		logic [10:0] base;
		logic valid;
		logic [7:0] data;
		logic last;
		logic done;
	} pad_t;

	typedef struct packed {
		sock_t sk;
		logic ipm;
		logic [7:0] mode;
		logic [7:0] proto;
		logic [11:0] wrsize;
		logic [47:0] mac;
		logic [31:0] dip;
		logic send_complete_flag;
		logic waitreq;
		logic [31:0] rdata;
		rx_t rx;
		logic rx_ready;
		logic [11:0] idx;
		logic [11:0] st;
		logic [11:0] wp;
		logic [11:0] cm;
		logic [11:0] rd;
		logic [11:0] rel;
		logic drop;
		logic [31:0] dl;
		logic [3:0] tc;
		logic [11:0] rlen;
		logic [11:0] twp;
		logic [11:0] trd;
		logic [11:0] tnext;
		logic busy;
	} sock_state_t;

endpackage

`default_nettype wire

// [rtl/raw_socket.sv]
// Socket zero raw engine: raw IP and raw Ethernet records, Avalon-MM registers, send path.
// Assumes a byte-wide link with valid/ready, and claim decisions of other sockets at frame end.
//
// The Avalon-MM slave port and the register offsets were decided locally.
`include "raw_sock_defs.svh"
`default_nettype none

module raw_socket
	import raw_sock_pkg::*;
#(
	parameter int SOCKET_INDEX = 0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Link receive
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	input wire logic rx_claimed,
	output logic rx_ready,
	// Link transmit
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	output logic tx_ip_mode,
	output logic [7:0] tx_ip_proto,
	output logic [31:0] tx_dest_ip
);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		merge = old;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) merge[8 * k +: 8] = wd[8 * k +: 8];
		end
	endfunction

	function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] k);
		byte_of = w[8'(31 - 8 * k) -: 8];
	endfunction

	sock_state_t c, n;

	logic [7:0] rx_mem [2**`BUF_AW];
	logic [15:0] tx_mem [2**(`BUF_AW - 1)];

	logic we;
	logic [11:0] wa;
	logic [7:0] wd;
	logic twe;
	logic pad_start;
	logic pad_done;
	logic [10:0] pad_addr;
	logic [15:0] pad_word;
	logic [7:0] pad_byte;
	logic cls_mac_ok;
	logic cls_ip_ok;
	logic [7:0] cls_proto;
	logic [15:0] cls_tot;
	logic [31:0] cls_src;
	logic [15:0] fifo_word;
	logic [11:0] plen;
	logic [11:0] hdr;

	assign pad_word = tx_mem[pad_addr[10:1]];
	assign pad_byte = pad_addr[0] ? pad_word[7:0] : pad_word[15:8];
	assign fifo_word = {rx_mem[c.rd[10:0]], rx_mem[11'(c.rd[10:0] + 11'h001)]};
	assign plen = cls_tot[11:0] - `IP_HDR_LEN;
	assign hdr = (c.sk == SK_IP) ? `HDR_IP : `HDR_ETH;

	rx_header_check u_check (
		.clk(clk),
		.reset(reset),
		.en(rx_valid && c.rx_ready),
		.data(rx_data),
		.idx(c.idx),
		.own_mac(c.mac),
		.mac_ok(cls_mac_ok),
		.ip_ok(cls_ip_ok),
		.proto(cls_proto),
		.tot(cls_tot),
		.src(cls_src)
	);

	tx_pad_sender u_send (
		.clk(clk),
		.reset(reset),
		.start(pad_start),
		.pad_en(c.sk == SK_ETH),
		.len(c.wrsize),
		.base(c.trd[10:0]),
		.done(pad_done),
		.rd_addr(pad_addr),
		.rd_data(pad_byte),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_last(tx_last),
		.tx_ready(tx_ready)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic take;
		logic [7:0] cmd;
		logic [11:0] i;
		logic [11:0] st;
		logic [11:0] wp;
		logic drop;
		logic store;
		logic [7:0] sb;
		logic ok;
		logic [3:0] j;
		take = 1'b0;
		cmd = 8'h00;
		i = c.idx;
		st = c.st;
		wp = c.wp;
		drop = c.drop;
		store = 1'b0;
		sb = 8'h00;
		ok = 1'b0;
		j = 4'h0;
		n = c;
		we = 1'b0;
		wa = '0;
		wd = 8'h00;
		twe = 1'b0;
		pad_start = 1'b0;

		// One wait cycle: answer prepared at the edge the request is first seen
		take = (read || write) && !c.waitreq;
		n.waitreq = !((read || write) && c.waitreq);
		if (read && c.waitreq) begin
			unique case (address)
				`OFS_MODE: n.rdata = {24'h000000, c.mode};
				`OFS_STATE: n.rdata = {24'h000000, c.sk == SK_IP ? `CODE_RAW_IP :
					c.sk == SK_ETH ? `CODE_RAW_ETH : `CODE_CLOSED};
				`OFS_IRQ: n.rdata = {31'h00000000, c.send_complete_flag};
				`OFS_PROTO: n.rdata = {24'h000000, c.proto};
				`OFS_TX_WRSIZE: n.rdata = {20'h00000, c.wrsize};
				`OFS_TX_FREE: n.rdata = {20'h00000, 12'(`BUF_BYTES - (c.twp - c.trd))};
				`OFS_RX_STORED: n.rdata = {20'h00000, 12'(c.cm - c.rd)};
				`OFS_RX_FIFO: n.rdata = (c.rd != c.cm) ? {16'h0000, fifo_word} : 32'h00000000;
				`OFS_MAC_HI: n.rdata = {16'h0000, c.mac[47:32]};
				`OFS_MAC_LO: n.rdata = c.mac[31:0];
				`OFS_DEST_IP: n.rdata = c.dip;
				default: n.rdata = 32'h00000000;
			endcase
		end

		if (take && read && address == `OFS_RX_FIFO && c.rd != c.cm) n.rd = c.rd + 12'h002;

		if (take && write) begin
			unique case (address)
				`OFS_MODE: n.mode = 8'(merge({24'h000000, c.mode}, writedata, byteenable));
				`OFS_COMMAND: if (byteenable[0]) cmd = writedata[7:0];
				`OFS_IRQ: if (byteenable[0] && writedata[`IRQ_SEND_BIT]) n.send_complete_flag = 1'b0;
				`OFS_PROTO: n.proto = 8'(merge({24'h000000, c.proto}, writedata, byteenable));
				`OFS_TX_WRSIZE: n.wrsize = 12'(merge({20'h00000, c.wrsize}, writedata, byteenable));
				`OFS_MAC_HI: n.mac[47:32] = 16'(merge({16'h0000, c.mac[47:32]}, writedata, byteenable));
				`OFS_MAC_LO: n.mac[31:0] = merge(c.mac[31:0], writedata, byteenable);
				`OFS_DEST_IP: n.dip = merge(c.dip, writedata, byteenable);
				`OFS_TX_FIFO: begin
					// A word that does not fit is dropped
					if (12'(`BUF_BYTES - (c.twp - c.trd)) >= 12'h002) begin
						twe = 1'b1;
						n.twp = c.twp + 12'h002;
					end
				end
				default: ;
			endcase
		end

		if (cmd == `CMD_OPEN && c.sk == SK_CLOSED) begin
			// Raw IP open, TCP and UDP refused
			if (c.mode[3:0] == `MODE_RAW_IP && c.proto != `PROTO_TCP && c.proto != `PROTO_UDP) n.sk = SK_IP;
			// Raw Ethernet open, socket zero only
			if (c.mode[3:0] == `MODE_RAW_ETH && SOCKET_INDEX == 0) n.sk = SK_ETH;
		end
		if (cmd == `CMD_CLOSE) n.sk = SK_CLOSED;
		// Freed space is what the host has read up to now
		if (cmd == `CMD_RECEIVE_DONE_COMMAND) n.rel = c.rd;
		if (cmd == `CMD_SEND && c.sk != SK_CLOSED && !c.busy) begin
			pad_start = 1'b1;
			n.busy = 1'b1;
			n.tnext = c.trd + c.wrsize + {11'h000, c.wrsize[0]};
		end
		// Completion only by flag, set wins
		if (pad_done) begin
			n.busy = 1'b0;
			n.trd = c.tnext;
			n.send_complete_flag = 1'b1;
		end
		n.ipm = n.sk == SK_IP;

		////////////////////////////////////////////////////////////////////////////////
		// Receive

		unique case (c.rx)
			RX_FRAME: begin
				if (rx_valid && c.rx_ready) begin
					if (i == 12'h000) begin
						st = c.cm;
						wp = c.cm + hdr;
						drop = c.sk == SK_CLOSED;
					end
					n.dl = {c.dl[23:0], rx_data};
					if (c.sk == SK_ETH && i >= 12'h004) begin
						store = 1'b1;
						sb = c.dl[31:24];
					end
					if (c.sk == SK_IP && i >= `IP_PAYLOAD_OFS && i < `IP_PAYLOAD_OFS + plen) begin
						store = 1'b1;
						sb = rx_data;
					end
					if (store && 12'(wp - c.rel) + `RX_RESERVE > `BUF_BYTES) drop = 1'b1;
					if (store && !drop) begin
						we = 1'b1;
						wa = wp;
						wd = sb;
						wp = wp + 12'h001;
					end
					n.idx = i + 12'h001;
					if (rx_last) begin
						n.idx = '0;
						if (c.sk == SK_ETH) begin
							ok = !drop && !rx_claimed && i >= 12'h004 && (!c.mode[`MODE_FILTER_BIT] || cls_mac_ok);
							n.rlen = i - 12'h003;
						end
						if (c.sk == SK_IP) begin
							ok = !drop && cls_ip_ok && cls_proto == c.proto && wp - st - `HDR_IP == plen;
							n.rlen = plen;
						end
						if (ok) begin
							n.rx = RX_TAIL;
							n.tc = 4'h0;
							n.rx_ready = 1'b0;
						end
					end
					n.st = st;
					n.wp = wp;
					n.drop = drop;
				end
			end
			RX_TAIL: begin
				// Pad odd data to a word
				if (c.tc == 4'h0 && c.rlen[0]) begin
					we = 1'b1;
					wa = c.wp;
					n.wp = c.wp + 12'h001;
				end
				if (c.tc >= 4'h1 && c.tc <= 4'h4 && c.sk == SK_ETH) begin
					we = 1'b1;
					wa = c.wp;
					wd = byte_of(c.dl, 2'(c.tc - 4'h1));
					n.wp = c.wp + 12'h001;
				end
				// Record header last, at the record start
				if (c.tc >= 4'h5) begin
					j = c.tc - 4'h5;
					if ({8'h00, j} < hdr) begin
						we = 1'b1;
						wa = c.st + {8'h00, j};
						if (c.sk == SK_IP && j < 4'h4) wd = byte_of(cls_src, j[1:0]);
						else if (j[0]) wd = c.rlen[7:0];
						else wd = {4'h0, c.rlen[11:8]};
					end
				end
				n.tc = c.tc + 4'h1;
				if (c.tc == `TAIL_LAST) begin
					n.cm = c.wp;
					n.rx = RX_FRAME;
					n.rx_ready = 1'b1;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers and memories

	always_ff @(posedge clk) begin
		if (reset) begin
			c <= '0;
			c.waitreq <= 1'b1;
			c.rx_ready <= 1'b1;
		end else begin
			c <= n;
		end
	end

	// Memories carry no reset; pointers decide what is valid
	always_ff @(posedge clk) begin
		if (we) rx_mem[wa[10:0]] <= wd;
		if (twe) tx_mem[c.twp[10:1]] <= writedata[15:0];
	end

	assign readdata = c.rdata;
	assign waitrequest = c.waitreq;
	assign rx_ready = c.rx_ready;
	assign tx_ip_mode = c.ipm;
	assign tx_ip_proto = c.proto;
	assign tx_dest_ip = c.dip;

endmodule // raw_socket

`default_nettype wire

// [rtl/rx_header_check.sv]
// Watches the bytes of each received frame, checks the destination address and keeps the type and IP header fields.
// Assumes byte index zero marks the first byte of a frame.
`include "raw_sock_defs.svh"
`default_nettype none

module rx_header_check
	import raw_sock_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Byte stream
	input wire logic en,
	input wire logic [7:0] data,
	input wire logic [11:0] idx,
	input wire logic [47:0] own_mac,
	// Decoded fields
	output logic mac_ok,
	output logic ip_ok,
	output logic [7:0] proto,
	output logic [15:0] tot,
	output logic [31:0] src
);

	function automatic logic [7:0] mac_byte(input logic [47:0] m, input logic [2:0] k);
		mac_byte = m[8'(47 - 8 * k) -: 8];
	endfunction

	cls_t c, n;

	always_comb begin
		n = c;
		if (en) begin
			if (idx < 12'h006) begin
				n.mac_ok = (idx == 12'h000 || c.mac_ok) && data == mac_byte(own_mac, idx[2:0]);
			end
			if (idx == 12'h00c) n.etype[15:8] = data;
			if (idx == 12'h00d) n.etype[7:0] = data;
			if (idx == 12'h00e) n.vihl = data;
			if (idx == 12'h010) n.tot[15:8] = data;
			if (idx == 12'h011) n.tot[7:0] = data;
			// More-fragments flag or any offset marks a fragment
			if (idx == 12'h014) n.frag = data[5] | (|data[4:0]);
			if (idx == 12'h015) n.frag = c.frag | (|data);
			if (idx == 12'h017) n.proto = data;
			if (idx >= 12'h01a && idx <= 12'h01d) n.src = {c.src[23:0], data};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) c <= '0;
		else c <= n;
	end

	assign mac_ok = c.mac_ok;
	assign ip_ok = c.etype == `ETHERTYPE_IP && c.vihl == `IP_VER_IHL && !c.frag;
	assign proto = c.proto;
	assign tot = c.tot;
	assign src = c.src;

endmodule // rx_header_check

`default_nettype wire

// [rtl/tx_pad_sender.sv]
// Streams one stored send out as bytes, filling short Ethernet sends with zeros.
// Assumes the memory read port answers in the same cycle as rd_addr.
`include "raw_sock_defs.svh"
`default_nettype none

module tx_pad_sender
	import raw_sock_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic pad_en,
	input wire logic [11:0] len,
	input wire logic [10:0] base,
	output logic done,
	// Memory read
	output logic [10:0] rd_addr,
	input wire logic [7:0] rd_data,
	// Byte stream
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready
);

	pad_t c, n;

	always_comb begin
		n = c;
		n.done = 1'b0;
		if (c.valid && tx_ready) n.valid = 1'b0;
		unique case (c.st)
			TX_IDLE: begin
				if (start) begin
					n.st = TX_RUN;
					n.i = '0;
					n.len = len;
					n.base = base;
					n.n = (pad_en && len < `ETH_MIN_LEN) ? `ETH_MIN_LEN : len;
				end
			end
			TX_RUN: begin
				if (!c.valid || tx_ready) begin
					if (c.i == c.n) begin
						n.st = TX_IDLE;
						n.done = 1'b1;
					end else begin
						n.valid = 1'b1;
						n.data = (c.i < c.len) ? rd_data : 8'h00;
						n.last = c.i == c.n - 12'h001;
						n.i = c.i + 12'h001;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) c <= '0;
		else c <= n;
	end

	assign rd_addr = c.base + c.i[10:0];
	assign done = c.done;
	assign tx_valid = c.valid;
	assign tx_data = c.data;
	assign tx_last = c.last;

endmodule // tx_pad_sender

`default_nettype wire

// [test/link_peer.sv]
// Link side model: sends received frames byte by byte, sinks sent bytes with stalls.
// Assumes frame byte i is 8'h10+i, an IPv4 header laid over it for a given protocol, check bytes 8'hc0 upward.
`default_nettype none

module link_peer (
	// Clock
	input wire logic clk,
	// Receive toward the block
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last,
	output logic rx_claimed,
	input wire logic rx_ready,
	// Send from the block
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] got[$];
	int lastpos = -1;
	logic [3:0] cnt = 4'h0;

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h5a;
		rx_last = 1'b0;
		rx_claimed = 1'b0;
		tx_ready = 1'b0;
	end

	// Nonzero protocol: type, version, length, no fragment and protocol over the pattern
	function automatic logic [7:0] fbyte(input int k, input int n, input logic [7:0] pr);
		fbyte = 8'h10 + 8'(k);
		if (pr != 8'h00) begin
			if (k == 12)
				fbyte = 8'h08;
			if (k == 13 || k == 16 || k == 20 || k == 21)
				fbyte = 8'h00;
			if (k == 14)
				fbyte = 8'h45;
			if (k == 17)
				fbyte = 8'(n - 14);
			if (k == 23)
				fbyte = pr;
		end
	endfunction

	// Payload bytes, then check bytes counted in rx_last; a stuck stall gives up
	task automatic send_frame(input int n, input logic cl, input logic [7:0] pr, output logic to);
		int i;
		int t;
		i = 0;
		t = 0;
		while (i < n + 4 && t < 200) begin
			rx_valid <= 1'b1;
			rx_data <= (i < n) ? fbyte(i, n, pr) : 8'hc0 + 8'(i - n);
			rx_last <= (i == n + 3);
			rx_claimed <= cl;
			@(posedge clk);
			t++;
			if (rx_ready)
				i++;
		end
		to = (i < n + 4);
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		rx_claimed <= ~cl;
		rx_data <= ~rx_data;
	endtask

	// Stall one cycle in four so the hold rule is exercised
	always @(posedge clk) begin
		cnt <= cnt + 4'h1;
		tx_ready <= (cnt[1:0] != 2'b00);
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			if (tx_last)
				lastpos = got.size() - 1;
		end
	end

endmodule // link_peer

`default_nettype wire

// [test/raw_socket_monitor.sv]
// Checker for the raw socket ports: bus answer, receive stall, send stream.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module raw_socket_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Bus
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	// Link
	input wire logic rx_valid,
	input wire logic rx_last,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_ready,
	input wire logic tx_ip_mode,
	input wire logic [7:0] tx_ip_proto
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	logic [11:0] sent_q;
	logic [11:0] sent_d;

	always_comb begin
		sent_d = sent_q;
		if (tx_valid && tx_ready)
			sent_d = tx_last ? 12'h000 : sent_q + 12'h001;
	end

	always_ff @(posedge clk) begin
		if (reset)
			sent_q <= 12'h000;
		else
			sent_q <= sent_d;
	end

	////////////////////////////////////////////////////////////////
	a_reset_rest: assert property ($fell(reset) |-> waitrequest && rx_ready && !tx_valid && !tx_ip_mode)
		else $error("outputs not at rest after reset");
	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus request not answered next cycle");
	a_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_wait_idle: assert property (!read && !write && waitrequest |=> waitrequest)
		else $error("waitrequest low without a request");
	a_rx_stall: assert property ($fell(rx_ready) |-> $past(rx_valid && rx_last) ##10 !rx_ready ##1 rx_ready)
		else $error("receive stall not eleven cycles after last byte");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("send byte changed before acceptance");
	a_tx_drop: assert property ($fell(tx_valid) |-> $past(tx_ready && tx_last))
		else $error("send stream ended without last byte");
	a_pad_min: assert property (tx_valid && tx_ready && tx_last && !tx_ip_mode |-> sent_q >= 12'h03b)
		else $error("raw Ethernet send shorter than sixty bytes");
	a_proto_ok: assert property (tx_ip_mode |-> tx_ip_proto != 8'h06 && tx_ip_proto != 8'h11)
		else $error("raw IP open with TCP or UDP number");

	c_rx_frame: cover property (rx_valid && rx_ready && rx_last);
	c_tx_frame: cover property (tx_valid && tx_ready && tx_last);
	c_ip_open: cover property ($rose(tx_ip_mode));

endmodule // raw_socket_monitor

bind raw_socket raw_socket_monitor raw_socket_monitor_inst (.clk(clk), .reset(reset), .read(read),
	.write(write), .waitrequest(waitrequest), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
	.tx_ip_mode(tx_ip_mode), .tx_ip_proto(tx_ip_proto));

`default_nettype wire

// [test/tb_top.sv]
// Testbench of raw_socket: register bus tasks, receive records, padded send.
// Assumes link_peer on the link side and the bound checker.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic reset = 1'b1;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic [31:0] rd;
	logic waitrequest, rx_valid, rx_last, rx_claimed, rx_ready, tx_valid, tx_last, tx_ready, tx_ip_mode;
	logic [7:0] rx_data, tx_data, tx_ip_proto;
	logic [31:0] tx_dest_ip;
	int fail_count = 0;
	int num_checks = 0;

	always #4 clk = ~clk;

	raw_socket raw_socket_inst (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_claimed(rx_claimed),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .tx_ip_mode(tx_ip_mode), .tx_ip_proto(tx_ip_proto), .tx_dest_ip(tx_dest_ip));

	link_peer link_peer_inst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.rx_claimed(rx_claimed), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_ready(tx_ready));

	////////////////////////////////////////////////////////////////
	task complete_run;
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Held until waitrequest is sampled low; idle cycle after
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		rd = readdata;
		if (k >= 50) begin
			fail_count++;
			complete_run;
		end
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask

	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask

	// One frame in, then time for its record to commit
	task frame(input int n, input logic cl, input logic [7:0] pr);
		logic to;
		link_peer_inst.send_frame(n, cl, pr, to);
		if (to) begin
			fail_count++;
			complete_run;
		end
		repeat (14) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////
	task t_reset;
		rchk("state", 8'h08, 32'h0);
		rchk("irq", 8'h0c, 32'h0);
		rchk("unmapped", 8'h3c, 32'h0);
	endtask

	task t_raw_ip;
		bus(1'b1, 8'h10, 32'h06);
		bus(1'b1, 8'h00, 32'h03);
		bus(1'b1, 8'h04, 32'h01);
		rchk("state tcp", 8'h08, 32'h00);
		bus(1'b1, 8'h10, 32'h01);
		bus(1'b1, 8'h30, 32'h0a000001);
		bus(1'b1, 8'h04, 32'h01);
		rchk("state ip", 8'h08, 32'h0a);
		chk("ip mode", {31'h0, tx_ip_mode}, 32'h1);
		chk("ip proto", {24'h0, tx_ip_proto}, 32'h01);
		chk("dest ip", tx_dest_ip, 32'h0a000001);
		frame(38, 1'b0, 8'h01);
		frame(38, 1'b0, 8'h02);
		rchk("ip stored", 8'h1c, 32'h0a);
		rchk("sender hi", 8'h20, 32'h2a2b);
		rchk("sender lo", 8'h20, 32'h2c2d);
		rchk("ip length", 8'h20, 32'h0004);
		rchk("ip data", 8'h20, 32'h3233);
		rchk("ip data", 8'h20, 32'h3435);
		bus(1'b1, 8'h04, 32'h40);
		bus(1'b1, 8'h04, 32'h10);
		rchk("state closed", 8'h08, 32'h00);
	endtask

	task t_eth_rx;
		int k;
		logic [7:0] b0, b1;
		bus(1'b1, 8'h00, 32'h04);
		bus(1'b1, 8'h04, 32'h01);
		rchk("state eth", 8'h08, 32'h0b);
		frame(15, 1'b0, 8'h00);
		rchk("stored", 8'h1c, 32'h16);
		frame(15, 1'b1, 8'h00);
		rchk("stored claimed", 8'h1c, 32'h16);
		rchk("length word", 8'h20, 32'h0f);
		for (k = 0; k < 8; k++) begin
			b0 = 8'h10 + 8'(2 * k);
			b1 = (k == 7) ? 8'h00 : 8'h11 + 8'(2 * k);
			rchk("data word", 8'h20, {16'h0, b0, b1});
		end
		rchk("check word", 8'h20, 32'hc0c1);
		rchk("check word", 8'h20, 32'hc2c3);
		bus(1'b1, 8'h04, 32'h40);
		rchk("stored done", 8'h1c, 32'h0);
		bus(1'b1, 8'h00, 32'h44);
		frame(15, 1'b0, 8'h00);
		rchk("stored foreign", 8'h1c, 32'h0);
		bus(1'b1, 8'h28, 32'h1011);
		bus(1'b1, 8'h2c, 32'h12131415);
		frame(15, 1'b0, 8'h00);
		rchk("stored own", 8'h1c, 32'h16);
	endtask

	task t_eth_tx;
		int k;
		rchk("tx free", 8'h18, 32'h800);
		bus(1'b1, 8'h24, 32'ha1b2);
		bus(1'b1, 8'h24, 32'hc3d4);
		bus(1'b1, 8'h14, 32'h4);
		bus(1'b1, 8'h04, 32'h20);
		k = 0;
		while (link_peer_inst.lastpos < 0 && k < 500) begin
			@(posedge clk);
			k++;
		end
		if (k >= 500) begin
			fail_count++;
			complete_run;
		end
		repeat (4) @(posedge clk);
		chk("sent count", link_peer_inst.got.size(), 32'h3c);
		chk("last index", link_peer_inst.lastpos, 32'h3b);
		for (k = 0; k < 60 && k < link_peer_inst.got.size(); k++)
			chk("sent byte", link_peer_inst.got[k], (k < 4) ? 32'ha1 + 32'h11 * 32'(k) : 32'h0);
		rchk("irq set", 8'h0c, 32'h1);
		rchk("tx free done", 8'h18, 32'h800);
		bus(1'b1, 8'h0c, 32'h1);
		rchk("irq clear", 8'h0c, 32'h0);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset;
		t_raw_ip;
		t_eth_rx;
		t_eth_tx;
		complete_run;
	end

endmodule // tb_top

`default_nettype wire
